// >>> rtl/fcsu_unit.sv
// Contract
// - status bits 3, 1 and 0 read zero, writes ignored
// - writing one to buffer-empty flag clears it and launches the command
// - buffer-empty also sets when a queued burst moves to the array
// - buffer-empty zero means full; one means another burst may be written
// - complete flag set when buffer empty and idle; clears on launch
// - software writes to complete flag are ignored
// - program or erase of protected location discarded, sets violation flag
// - violation flag cleared only by writing one
// - broken command-writing sequence discards command, sets access error
// - program or erase before divider written raises access error, no run
// - stop entry while a command runs raises access error
// - access error cleared only by writing one
// - blank check sets blank flag if whole array erased
// - blank flag clears on valid launch; software writes ignored
// - codes 05 blank, 20 byte program, 25 burst program accepted
// - code 40 erases a 512-byte page, 41 erases the whole array
// - any other code raises access error and does not run
// - mass erase refused with violation when any sector is protected
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "fcsu_params.svh"
module fcsu_unit
    import fcsu_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic stop_req,
    output logic [7:0] rdata,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////
    function automatic logic is_legal(input logic [7:0] c);
        return c == `FCSU_CMD_BLANK || c == `FCSU_CMD_BYTE || c == `FCSU_CMD_BURST
            || c == `FCSU_CMD_PAGE || c == `FCSU_CMD_MASS;
    endfunction
    function automatic logic is_modify(input logic [7:0] c);
        return c != `FCSU_CMD_BLANK;
    endfunction
    // protect register: bit0 disables protection, bits 7:1 bound in 8-byte units
    function automatic logic is_prot(input logic [7:0] p, input logic [9:0] a);
        return !p[0] && (a[9:3] >= p[7:1]);
    endfunction
    ////////////////////////////////////////////////////////////////////
    fcsu_state_e state, next_state;
    logic bef, next_bef;
    logic pviol, next_pviol, accerr, next_accerr, blank, next_blank;
    logic div_set, next_div_set;
    logic [7:0] divider, next_divider, protect, next_protect;
    // staging: data written, then command written; pending bits track order
    fcsu_cmd_s stage, next_stage;
    logic have_data, next_have_data, have_cmd, next_have_cmd;
    fcsu_cmd_s cur, next_cur, queued, next_queued;
    logic q_full, next_q_full;
    logic [9:0] ptr, next_ptr;
    logic [7:0] tmr, next_tmr;
    logic [7:0] next_rdata;
    logic next_busy;
    fcsu_mem_s mreq;
    logic [9:0] raddr;
    logic [7:0] mrd;
    logic scan_fail, next_scan_fail;
    logic launch, w_status, w_cmd;
    logic [7:0] status_word;
    logic [9:0] prot_addr;

    fcsu_array u_array (
        .mclk(mclk),
        .req(mreq),
        .raddr(raddr),
        .rdata(mrd)
    );

    assign w_status = wr && addr == `FCSU_ADDR_STATUS;
    assign w_cmd = wr && addr == `FCSU_ADDR_COMMAND;
    assign launch = w_status && wdata[`FCSU_BIT_BEF] && bef;
    // guarded region sits at the top, so a page's last byte decides the page
    assign prot_addr = (stage.cmd == `FCSU_CMD_PAGE) ? {stage.addr[9], 9'h1ff} : stage.addr;

    always_comb begin
        status_word = 8'h00;
        status_word[`FCSU_BIT_BEF] = bef;
        status_word[`FCSU_BIT_CCF] = bef && state == FCSU_IDLE;
        status_word[`FCSU_BIT_PVIOL] = pviol;
        status_word[`FCSU_BIT_ACCERR] = accerr;
        status_word[`FCSU_BIT_BLANK] = blank;
    end

    ////////////////////////////////////////////////////////////////////
    // command engine
    always_comb begin
        next_state = state;
        next_bef = bef;
        next_pviol = pviol;
        next_accerr = accerr;
        next_blank = blank;
        next_stage = stage;
        next_have_data = have_data;
        next_have_cmd = have_cmd;
        next_cur = cur;
        next_queued = queued;
        next_q_full = q_full;
        next_ptr = ptr;
        next_tmr = tmr;
        next_scan_fail = scan_fail;
        mreq = '0;
        raddr = ptr;
        // data write stores into staging; starts a sequence
        if (wr && addr == `FCSU_ADDR_DATA) begin
            next_stage.data = wdata;
            next_have_data = 1'b1;
        end
        if (wr && addr == `FCSU_ADDR_ADDRLO) begin
            next_stage.addr[7:0] = wdata;
        end
        if (wr && addr == `FCSU_ADDR_ADDRHI) begin
            next_stage.addr[9:8] = wdata[1:0];
        end
        if (w_cmd) begin
            next_stage.cmd = wdata;
            if (!have_data) begin
                next_accerr = 1'b1;
            end else begin
                next_have_cmd = 1'b1;
            end
        end
        // software clears error flags by writing one; writes to bits 6, 2 ignored
        if (w_status && wdata[`FCSU_BIT_PVIOL]) begin
            next_pviol = 1'b0;
        end
        if (w_status && wdata[`FCSU_BIT_ACCERR]) begin
            next_accerr = 1'b0;
        end
        // engine progress
        unique case (state)
            FCSU_IDLE: begin
                if (q_full) begin
                    next_cur = queued;
                    next_q_full = 1'b0;
                    next_tmr = `FCSU_PROG_CYCLES;
                    next_state = FCSU_RUN;
                end
            end
            FCSU_RUN: begin
                next_tmr = tmr - 8'h01;
                if (tmr == 8'h01) begin
                    mreq.we = 1'b1;
                    mreq.addr = cur.addr;
                    mreq.wdata = cur.data;
                    next_state = FCSU_IDLE;
                end
            end
            FCSU_SCAN: begin
                // read data lag one cycle; compare the word fetched last cycle
                if (ptr != 10'h000 && mrd != `FCSU_ERASED) begin
                    next_scan_fail = 1'b1;
                end
                next_ptr = ptr + 10'h001;
                if (ptr == 10'(`FCSU_ARRAY_BYTES - 1)) begin
                    next_state = FCSU_ERASE;
                    next_tmr = 8'h00;
                end
            end
            FCSU_ERASE: begin
                if (cur.cmd == `FCSU_CMD_BLANK) begin
                    next_blank = !(scan_fail || mrd != `FCSU_ERASED);
                    next_state = FCSU_IDLE;
                end else begin
                    mreq.we = 1'b1;
                    mreq.addr = ptr;
                    mreq.wdata = `FCSU_ERASED;
                    next_ptr = ptr + 10'h001;
                    if (cur.cmd == `FCSU_CMD_PAGE) begin
                        if (ptr[8:0] == 9'(`FCSU_PAGE_BYTES - 1)) begin
                            next_state = FCSU_IDLE;
                        end
                    end else if (ptr == 10'(`FCSU_ARRAY_BYTES - 1)) begin
                        next_state = FCSU_IDLE;
                    end
                end
            end
        endcase
        // queued burst moves to the array: buffer frees for the next one
        if (state == FCSU_IDLE && q_full) begin
            next_bef = 1'b1;
        end
        // erase or scan has taken the command: buffer is empty again
        if ((state == FCSU_SCAN || state == FCSU_ERASE) && !q_full) begin
            next_bef = 1'b1;
        end
        if (launch) begin
            next_have_data = 1'b0;
            next_have_cmd = 1'b0;
            if (!have_cmd || !is_legal(stage.cmd)) begin
                next_accerr = 1'b1;
            end else if (is_modify(stage.cmd) && !div_set) begin
                next_accerr = 1'b1;
            end else if (stage.cmd == `FCSU_CMD_MASS && !protect[0]) begin
                next_pviol = 1'b1;
            end else if (is_modify(stage.cmd) && stage.cmd != `FCSU_CMD_MASS
                         && is_prot(protect, prot_addr)) begin
                next_pviol = 1'b1;
            end else if (state != FCSU_IDLE && stage.cmd != `FCSU_CMD_BURST) begin
                next_accerr = 1'b1;
            end else begin
                next_blank = 1'b0;
                next_bef = 1'b0;
                if (stage.cmd == `FCSU_CMD_BYTE || stage.cmd == `FCSU_CMD_BURST) begin
                    next_queued = stage;
                    next_q_full = 1'b1;
                end else begin
                    next_cur = stage;
                    next_scan_fail = 1'b0;
                    next_ptr = (stage.cmd == `FCSU_CMD_PAGE)
                        ? {stage.addr[9], 9'h000} : 10'h000;
                    next_state = (stage.cmd == `FCSU_CMD_BLANK) ? FCSU_SCAN : FCSU_ERASE;
                end
            end
        end
        // stop while a command runs aborts and flags it
        if (stop_req && (state != FCSU_IDLE || q_full)) begin
            next_accerr = 1'b1;
            next_state = FCSU_IDLE;
            next_q_full = 1'b0;
            next_bef = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= FCSU_IDLE;
            bef <= 1'b1;
            pviol <= 1'b0;
            accerr <= 1'b0;
            blank <= 1'b0;
            stage <= '0;
            have_data <= 1'b0;
            have_cmd <= 1'b0;
            cur <= '0;
            queued <= '0;
            q_full <= 1'b0;
            ptr <= 10'h000;
            tmr <= 8'h00;
            scan_fail <= 1'b0;
        end else begin
            state <= next_state;
            bef <= next_bef;
            pviol <= next_pviol;
            accerr <= next_accerr;
            blank <= next_blank;
            stage <= next_stage;
            have_data <= next_have_data;
            have_cmd <= next_have_cmd;
            cur <= next_cur;
            queued <= next_queued;
            q_full <= next_q_full;
            ptr <= next_ptr;
            tmr <= next_tmr;
            scan_fail <= next_scan_fail;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration and read port
    always_comb begin
        next_divider = divider;
        next_div_set = div_set;
        next_protect = protect;
        if (wr && addr == `FCSU_ADDR_DIVIDER) begin
            next_divider = wdata;
            next_div_set = 1'b1;
        end
        // protection register takes any written value, whether it grows or shrinks
        if (wr && addr == `FCSU_ADDR_PROTECT) begin
            next_protect = wdata;
        end
        next_rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                `FCSU_ADDR_STATUS: next_rdata = status_word;
                `FCSU_ADDR_COMMAND: next_rdata = stage.cmd;
                `FCSU_ADDR_DIVIDER: next_rdata = {div_set, divider[6:0]};
                `FCSU_ADDR_PROTECT: next_rdata = protect;
                `FCSU_ADDR_ADDRLO: next_rdata = stage.addr[7:0];
                `FCSU_ADDR_ADDRHI: next_rdata = {6'h00, stage.addr[9:8]};
                `FCSU_ADDR_DATA: next_rdata = stage.data;
                `FCSU_ADDR_CONTROL: next_rdata = {7'h00, state != FCSU_IDLE};
            endcase
        end
        next_busy = next_state != FCSU_IDLE || next_q_full;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            divider <= 8'h00;
            div_set <= 1'b0;
            protect <= `FCSU_RST_PROTECT;
            rdata <= 8'h00;
            busy <= 1'b0;
        end else begin
            divider <= next_divider;
            div_set <= next_div_set;
            protect <= next_protect;
            rdata <= next_rdata;
            busy <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_launch;
        launch && !accerr && have_cmd;
    endsequence
    property p_ccf_clear;
        @(posedge mclk) disable iff (!resetn)
        (launch && next_bef == 1'b0) |=> !status_word[`FCSU_BIT_CCF];
    endproperty
    a_ccf_clear: assert property (p_ccf_clear) else $error("complete flag not cleared");
    property p_reserved;
        @(posedge mclk) disable iff (!resetn)
        rd && addr == `FCSU_ADDR_STATUS |=> (rdata & 8'h0b) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bits set");
    property p_illegal;
        @(posedge mclk) disable iff (!resetn)
        launch && have_cmd && !is_legal(stage.cmd) |=> accerr && bef;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal code not flagged");
    property p_pviol_hold;
        @(posedge mclk) disable iff (!resetn)
        pviol && !(w_status && wdata[`FCSU_BIT_PVIOL]) |=> pviol;
    endproperty
    a_pviol_hold: assert property (p_pviol_hold) else $error("violation lost");
    property p_acc_hold;
        @(posedge mclk) disable iff (!resetn)
        accerr && !(w_status && wdata[`FCSU_BIT_ACCERR]) |=> accerr;
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("access error lost");
    property p_nodiv;
        @(posedge mclk) disable iff (!resetn)
        launch && have_cmd && is_legal(stage.cmd) && is_modify(stage.cmd) && !div_set
        |=> accerr && state == FCSU_IDLE;
    endproperty
    a_nodiv: assert property (p_nodiv) else $error("run without divider");
    property p_stop;
        @(posedge mclk) disable iff (!resetn)
        stop_req && state != FCSU_IDLE |=> accerr ##0 state == FCSU_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not flagged");
    property p_prog_done;
        @(posedge mclk) disable iff (!resetn)
        state == FCSU_IDLE && q_full && !stop_req |=> state == FCSU_RUN ##8 state != FCSU_RUN;
    endproperty
    a_prog_done: assert property (p_prog_done) else $error("program timing wrong");
    property p_blank_clear;
        @(posedge mclk) disable iff (!resetn)
        s_launch ##0 (next_bef == 1'b0 && !stop_req) |=> !blank;
    endproperty
    a_blank_clear: assert property (p_blank_clear) else $error("blank not cleared");
endmodule
`default_nettype wire

// >>> rtl/fcsu_params.svh
`ifndef FCSU_PARAMS_SVH
`define FCSU_PARAMS_SVH
// register indices on the plain port
`define FCSU_ADDR_STATUS 3'h0
`define FCSU_ADDR_COMMAND 3'h1
`define FCSU_ADDR_DIVIDER 3'h2
`define FCSU_ADDR_PROTECT 3'h3
`define FCSU_ADDR_ADDRLO 3'h4
`define FCSU_ADDR_ADDRHI 3'h5
`define FCSU_ADDR_DATA 3'h6
`define FCSU_ADDR_CONTROL 3'h7
// status bit positions
`define FCSU_BIT_BEF 7
`define FCSU_BIT_CCF 6
`define FCSU_BIT_PVIOL 5
`define FCSU_BIT_ACCERR 4
`define FCSU_BIT_BLANK 2
// command codes
`define FCSU_CMD_BLANK 8'h05
`define FCSU_CMD_BYTE 8'h20
`define FCSU_CMD_BURST 8'h25
`define FCSU_CMD_PAGE 8'h40
`define FCSU_CMD_MASS 8'h41
// array geometry
`define FCSU_PAGE_BYTES 512
`define FCSU_ARRAY_BYTES 1024
`define FCSU_ERASED 8'hff
// operation timing in bus cycles
`define FCSU_PROG_CYCLES 8'h08
// reset values
`define FCSU_RST_COMMAND 8'h00
`define FCSU_RST_PROTECT 8'h01
`endif

// >>> rtl/fcsu_pkg.sv
package fcsu_pkg;
    typedef enum logic [3:0] {
        FCSU_IDLE = 4'b0001,
        FCSU_RUN = 4'b0010,
        FCSU_SCAN = 4'b0100,
        FCSU_ERASE = 4'b1000
    } fcsu_state_e;
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] data;
        logic [7:0] cmd;
    } fcsu_cmd_s;
    typedef struct packed {
        logic we;
        logic [9:0] addr;
        logic [7:0] wdata;
    } fcsu_mem_s;
endpackage

// >>> rtl/fcsu_array.sv
`timescale 1ns/10ps
`default_nettype none
module fcsu_array
    import fcsu_pkg::*;
(
    input wire logic mclk,
    input wire fcsu_mem_s req,
    input wire logic [9:0] raddr,
    output logic [7:0] rdata
);
    // no reset: array content is nonvolatile by nature
    logic [7:0] mem [0:1023];
    always_ff @(posedge mclk) begin
        if (req.we) begin
            mem[req.addr] <= req.wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// >>> tb/flash_command_status_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcsu_params.svh"
module flash_command_status_unit_tb_top;
logic mclk;
logic resetn;
logic [2:0] addr;
logic [7:0] wdata;
logic wr;
logic rd;
logic stop_req;
logic [7:0] rdata;
logic busy;
int fails;
int comparisons;

fcsu_unit DUT (
    .mclk(mclk),
    .resetn(resetn),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .stop_req(stop_req),
    .rdata(rdata),
    .busy(busy)
);

initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
end

////////////////////////////////////////////////////////////////////////////////
// bus tasks: strobe stays up between back-to-back writes, idle drops it
task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
endtask

task automatic idle();
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
endtask

task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
endtask

task automatic chk(input logic [7:0] g, input logic [7:0] m, input logic [7:0] e);
    comparisons++;
    if ((g & m) !== e) begin
        fails++;
        $display("BAD t=%0t got=%h exp=%h", $time, g & m, e);
    end
endtask

task automatic st(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(`FCSU_ADDR_STATUS, d);
    chk(d, m, e);
endtask

task automatic wst(input logic [7:0] d);
    wr_reg(`FCSU_ADDR_STATUS, d);
    idle();
endtask

task automatic launch(input logic [9:0] a, input logic [7:0] d, input logic [7:0] c);
    wr_reg(`FCSU_ADDR_ADDRLO, a[7:0]);
    wr_reg(`FCSU_ADDR_ADDRHI, {6'h00, a[9:8]});
    wr_reg(`FCSU_ADDR_DATA, d);
    wr_reg(`FCSU_ADDR_COMMAND, c);
    wr_reg(`FCSU_ADDR_STATUS, 8'h80);
    idle();
endtask

// bounded poll, long enough for a full-array scan
task automatic wait_ccf();
    logic [7:0] d;
    int n;
    d = 8'h00;
    n = 0;
    while (d[`FCSU_BIT_CCF] !== 1'b1 && n < 1500) begin
        rd_reg(`FCSU_ADDR_STATUS, d);
        n++;
    end
    if (n >= 1500) begin
        fails++;
        $display("BAD t=%0t ccf wait got=%h exp=%h", $time, d, 8'h40);
    end
endtask

task automatic done(input string s);
    $display("test %s finished", s);
endtask

task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////
task automatic t_reset();
    chk({7'h00, busy}, 8'hff, 8'h00);
    st(8'hff, 8'hc0);
    wst(8'h4f);
    st(8'hff, 8'hc0);
    done("reset");
endtask

// must run before any divider write
task automatic t_nodiv();
    launch(10'h000, 8'h00, `FCSU_CMD_BYTE);
    st(8'h10, 8'h10);
    wst(8'h00);
    st(8'h10, 8'h10);
    wst(8'h10);
    st(8'hff, 8'hc0);
    wr_reg(`FCSU_ADDR_DIVIDER, 8'h13);
    idle();
    done("nodiv");
endtask

task automatic t_illegal();
    launch(10'h000, 8'h00, 8'h33);
    st(8'h50, 8'h50);
    wst(8'h10);
    wr_reg(`FCSU_ADDR_COMMAND, `FCSU_CMD_BYTE);
    idle();
    st(8'h10, 8'h10);
    wst(8'h10);
    st(8'hff, 8'hc0);
    done("illegal");
endtask

// array powers up unknown, so erase comes first
task automatic t_erase_blank();
    logic [7:0] d;
    launch(10'h000, 8'h00, `FCSU_CMD_MASS);
    rd_reg(`FCSU_ADDR_CONTROL, d);
    chk(d, 8'hff, 8'h01);
    wait_ccf();
    launch(10'h000, 8'h00, `FCSU_CMD_BLANK);
    wait_ccf();
    st(8'h34, 8'h04);
    wst(8'h00);
    st(8'h04, 8'h04);
    launch(10'h005, 8'h5a, `FCSU_CMD_BYTE);
    st(8'h44, 8'h00);
    wait_ccf();
    launch(10'h000, 8'h00, `FCSU_CMD_BLANK);
    wait_ccf();
    st(8'h34, 8'h00);
    launch(10'h000, 8'h00, `FCSU_CMD_PAGE);
    wait_ccf();
    launch(10'h000, 8'h00, `FCSU_CMD_BLANK);
    wait_ccf();
    st(8'h34, 8'h04);
    done("erase_blank");
endtask

// second burst written while the first still runs
task automatic t_burst();
    launch(10'h040, 8'h01, `FCSU_CMD_BURST);
    wr_reg(`FCSU_ADDR_ADDRLO, 8'h41);
    wr_reg(`FCSU_ADDR_DATA, 8'h02);
    wr_reg(`FCSU_ADDR_COMMAND, `FCSU_CMD_BURST);
    wr_reg(`FCSU_ADDR_STATUS, 8'h80);
    idle();
    st(8'hd0, 8'h00);
    wait_ccf();
    st(8'hf0, 8'hc0);
    done("burst");
endtask

task automatic t_busy();
    launch(10'h010, 8'h11, `FCSU_CMD_BYTE);
    // busy is launched on the edge just passed; look once it has settled
    @(negedge mclk);
    chk({7'h00, busy}, 8'hff, 8'h01);
    launch(10'h011, 8'h12, `FCSU_CMD_BYTE);
    wait_ccf();
    st(8'h10, 8'h10);
    wst(8'h10);
    done("busy");
endtask

task automatic t_stop();
    launch(10'h020, 8'h21, `FCSU_CMD_BYTE);
    @(negedge mclk);
    chk({7'h00, busy}, 8'hff, 8'h01);
    @(posedge mclk);
    stop_req <= 1'b1;
    repeat (3) @(posedge mclk);
    stop_req <= 1'b0;
    wait_ccf();
    st(8'h10, 8'h10);
    wst(8'h10);
    st(8'hff, 8'hc0);
    done("stop");
endtask

// protection enabled: only the top eight bytes are guarded
task automatic t_protect();
    wr_reg(`FCSU_ADDR_PROTECT, 8'hfe);
    idle();
    launch(10'h3ff, 8'h33, `FCSU_CMD_BYTE);
    st(8'h30, 8'h20);
    wst(8'h00);
    st(8'h20, 8'h20);
    wst(8'h20);
    st(8'h20, 8'h00);
    launch(10'h000, 8'h00, `FCSU_CMD_MASS);
    st(8'h30, 8'h20);
    wst(8'h20);
    // upper page holds the guarded bytes, so its erase must be refused
    launch(10'h200, 8'h00, `FCSU_CMD_PAGE);
    st(8'h30, 8'h20);
    wst(8'h20);
    launch(10'h008, 8'h44, `FCSU_CMD_BYTE);
    wait_ccf();
    st(8'hf0, 8'hc0);
    done("protect");
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
    fails = 0;
    comparisons = 0;
    resetn = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    stop_req = 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_nodiv();
    t_illegal();
    t_erase_blank();
    t_burst();
    t_busy();
    t_stop();
    t_protect();
    results();
end

// scans dominate run time, roughly five thousand cycles in all
initial begin
    #400000;
    fails++;
    $display("BAD t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    results();
end
endmodule
`default_nettype wire
